// File: logic/mbh_ctrl.v
// Microcontroller bus host driving the peripheral's bus pins
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "mbh_defines.vh"

module mbh_ctrl (
  // Clock and reset
  input wire core_clk_in,
  input wire sys_rst_in,
  // APB slave
  input wire psel_in,
  input wire penable_in,
  input wire pwrite_in,
  input wire [7:0] paddr_in,
  input wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire pready_out,
  output wire pslverr_out,
  // Strobe and controls
  output wire address_latch_strobe_out,
  output wire rd_n_out,
  output wire wr_n_out,
  output wire byte_high_enable_n_out,
  // Low address/data pins
  input wire [7:0] low_addr_data_pins_in,
  output wire [7:0] low_addr_data_pins_out,
  output wire low_addr_data_pins_oe_n_out,
  // High address/data pins
  input wire [7:0] high_addr_data_pins_in,
  output wire [7:0] high_addr_data_pins_out,
  output wire high_addr_data_pins_oe_n_out,
  // Port A data lines
  input wire [7:0] port_a_lines_in,
  output wire [7:0] port_a_lines_out,
  output wire port_a_lines_oe_n_out,
  // Port B data lines
  input wire [7:0] port_b_lines_in,
  output wire [7:0] port_b_lines_out,
  output wire port_b_lines_oe_n_out,
  // Upper address
  output wire [2:0] port_c_lines_out,
  output wire addr19_or_chip_select_in_out
);

  // One-hot states
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ALE = 5'h02;
  localparam [4:0] ST_HOLD = 5'h04;
  localparam [4:0] ST_ACC = 5'h08;
  localparam [4:0] ST_REC = 5'h10;
  localparam integer ALE_N = `MBH_ALE_CYC;
  localparam integer HOLD_N = `MBH_HOLD_CYC;
  localparam integer ACC_N = `MBH_ACC_CYC;
  localparam integer REC_N = `MBH_REC_CYC;
  localparam [2:0] ALE_CYC = ALE_N[2:0];
  localparam [2:0] HOLD_CYC = HOLD_N[2:0];
  localparam [2:0] ACC_CYC = ACC_N[2:0];
  localparam [2:0] REC_CYC = REC_N[2:0];

  reg [2:0] ctrl_reg;
  reg [19:0] addr_reg;
  reg [15:0] wdata_reg;
  reg [15:0] rdata_reg;
  reg done_reg;
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [2:0] cnt_reg;
  reg [2:0] cnt_next;
  reg rd_op_reg;
  reg high_reg;
  reg ale_reg;
  reg rd_n_reg;
  reg wr_n_reg;
  reg bhe_n_reg;
  reg [7:0] lo_out_reg;
  reg lo_oe_n_reg;
  reg [7:0] hi_out_reg;
  reg hi_oe_n_reg;
  reg [7:0] pa_out_reg;
  reg pa_oe_n_reg;
  reg [7:0] pb_out_reg;
  reg pb_oe_n_reg;
  reg [2:0] pc_reg;
  reg a19_reg;
  reg [31:0] rd_mux;
  reg addr_ok;

  wire wr_acc;
  wire [1:0] mode;
  wire is_mux;
  wire is_16;
  wire go;
  wire finish;

  assign mode = ctrl_reg[`MBH_CTRL_MODE_HI:`MBH_CTRL_MODE_LO];
  assign is_mux = (mode == `MBH_MODE_MUX8) || (mode == `MBH_MODE_MUX16);
  assign is_16 = (mode == `MBH_MODE_MUX16) || (mode == `MBH_MODE_NMX16);
  assign wr_acc = psel_in && penable_in && pwrite_in;
  assign go = wr_acc && (paddr_in == `MBH_OFF_CMD) &&
              pwdata_in[`MBH_CMD_GO] && state_reg[0];
  assign finish = state_reg[4] && (cnt_reg == 3'h0);

  // Address decode for reads and unmapped check
  always @* begin
    rd_mux = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr_in)
      `MBH_OFF_CTRL: rd_mux = {29'h0, ctrl_reg};
      `MBH_OFF_ADDR: rd_mux = {12'h000, addr_reg};
      `MBH_OFF_WDATA: rd_mux = {16'h0000, wdata_reg};
      `MBH_OFF_CMD: rd_mux = {29'h0, high_reg, rd_op_reg, 1'b0};
      `MBH_OFF_STATUS: rd_mux = {30'h0, done_reg, ~state_reg[0]};
      `MBH_OFF_RDATA: rd_mux = {16'h0000, rdata_reg};
      default: addr_ok = 1'b0;
    endcase
  end

  assign prdata_out = rd_mux;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_ok;

  // Software registers; settings frozen while a cycle runs
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ctrl_reg <= `MBH_CTRL_RST;
      addr_reg <= 20'h00000;
      wdata_reg <= 16'h0000;
      rd_op_reg <= 1'b0;
      high_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      if (wr_acc && state_reg[0]) begin
        if (paddr_in == `MBH_OFF_CTRL)
          ctrl_reg <= pwdata_in[2:0];
        if (paddr_in == `MBH_OFF_ADDR)
          addr_reg <= pwdata_in[19:0];
        if (paddr_in == `MBH_OFF_WDATA)
          wdata_reg <= pwdata_in[15:0];
      end
      if (go) begin
        rd_op_reg <= pwdata_in[`MBH_CMD_READ];
        high_reg <= pwdata_in[`MBH_CMD_HIGH];
      end
      // Done is write-one-to-clear; completion wins
      if (finish)
        done_reg <= 1'b1;
      else if (wr_acc && (paddr_in == `MBH_OFF_STATUS) &&
               pwdata_in[`MBH_STAT_DONE])
        done_reg <= 1'b0;
    end
  end

  // Bus cycle sequencer
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (go) begin
          state_next = ST_ALE;
          cnt_next = ALE_CYC - 3'h1;
        end
      end
      ST_ALE: begin
        if (cnt_reg == 3'h0) begin
          state_next = ST_HOLD;
          cnt_next = HOLD_CYC - 3'h1;
        end else
          cnt_next = cnt_reg - 3'h1;
      end
      ST_HOLD: begin
        if (cnt_reg == 3'h0) begin
          state_next = ST_ACC;
          cnt_next = ACC_CYC - 3'h1;
        end else
          cnt_next = cnt_reg - 3'h1;
      end
      ST_ACC: begin
        if (cnt_reg == 3'h0) begin
          state_next = ST_REC;
          cnt_next = REC_CYC - 3'h1;
        end else
          cnt_next = cnt_reg - 3'h1;
      end
      ST_REC: begin
        if (cnt_reg == 3'h0)
          state_next = ST_IDLE;
        else
          cnt_next = cnt_reg - 3'h1;
      end
      default: begin
        state_next = ST_IDLE;
        cnt_next = 3'h0;
      end
    endcase
  end

  // State, pins and read capture
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 3'h0;
      ale_reg <= 1'b0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      bhe_n_reg <= 1'b1;
      lo_out_reg <= 8'h00;
      lo_oe_n_reg <= 1'b1;
      hi_out_reg <= 8'h00;
      hi_oe_n_reg <= 1'b1;
      pa_out_reg <= 8'h00;
      pa_oe_n_reg <= 1'b1;
      pb_out_reg <= 8'h00;
      pb_oe_n_reg <= 1'b1;
      pc_reg <= 3'h0;
      a19_reg <= 1'b1;
      rdata_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      // Strobe active only in address phase, any mode, and in reset
      ale_reg <= state_next[1] ~^ ctrl_reg[`MBH_CTRL_ALE_POL];
      rd_n_reg <= !(state_next[3] && rd_op_reg);
      wr_n_reg <= !(state_next[3] && !rd_op_reg);
      // First strobe edge takes the flag from the command being accepted
      bhe_n_reg <= !(is_16 && !state_next[0] &&
                     (go ? pwdata_in[`MBH_CMD_HIGH] : high_reg));
      pc_reg <= addr_reg[18:16];
      a19_reg <= addr_reg[19];
      if (state_next[1] || state_next[2]) begin
        // Address stays valid past the trailing strobe edge
        lo_out_reg <= addr_reg[7:0];
        hi_out_reg <= addr_reg[15:8];
        lo_oe_n_reg <= 1'b0;
        hi_oe_n_reg <= 1'b0;
        pa_oe_n_reg <= 1'b1;
        pb_oe_n_reg <= 1'b1;
      end else if (state_next[3]) begin
        if (is_mux) begin
          lo_out_reg <= wdata_reg[7:0];
          lo_oe_n_reg <= rd_op_reg;
          if (is_16) begin
            hi_out_reg <= wdata_reg[15:8];
            hi_oe_n_reg <= rd_op_reg;
          end
        end else begin
          pa_out_reg <= wdata_reg[7:0];
          pa_oe_n_reg <= rd_op_reg;
          pb_out_reg <= wdata_reg[15:8];
          pb_oe_n_reg <= rd_op_reg || !is_16;
        end
      end else begin
        lo_oe_n_reg <= !state_next[4] || is_mux;
        hi_oe_n_reg <= !state_next[4] || (is_mux && is_16);
        pa_oe_n_reg <= 1'b1;
        pb_oe_n_reg <= 1'b1;
      end
      // Read data taken on the last access cycle
      if (state_reg[3] && (cnt_reg == 3'h0) && rd_op_reg) begin
        if (is_mux) begin
          rdata_reg[7:0] <= low_addr_data_pins_in;
          rdata_reg[15:8] <= is_16 ? high_addr_data_pins_in : 8'h00;
        end else begin
          rdata_reg[7:0] <= port_a_lines_in;
          rdata_reg[15:8] <= is_16 ? port_b_lines_in : 8'h00;
        end
      end
    end
  end

  assign address_latch_strobe_out = ale_reg;
  assign rd_n_out = rd_n_reg;
  assign wr_n_out = wr_n_reg;
  assign byte_high_enable_n_out = bhe_n_reg;
  assign low_addr_data_pins_out = lo_out_reg;
  assign low_addr_data_pins_oe_n_out = lo_oe_n_reg;
  assign high_addr_data_pins_out = hi_out_reg;
  assign high_addr_data_pins_oe_n_out = hi_oe_n_reg;
  assign port_a_lines_out = pa_out_reg;
  assign port_a_lines_oe_n_out = pa_oe_n_reg;
  assign port_b_lines_out = pb_out_reg;
  assign port_b_lines_oe_n_out = pb_oe_n_reg;
  assign port_c_lines_out = pc_reg;
  assign addr19_or_chip_select_in_out = a19_reg;

endmodule // mbh_ctrl

// File: inc/mbh_defines.vh
// Constants for the microcontroller bus host controller
// Overview of operation
// - Address bits 16-18 on Port C, 19 shared
// - Non-mux 8-bit: address pins, data Port A
// - Non-mux 16-bit: data on Port A, B
// - Odd mux host wired non-mux, still strobes
`ifndef MBH_DEFINES_VH
`define MBH_DEFINES_VH

// Register byte offsets
`define MBH_OFF_CTRL 8'h00
`define MBH_OFF_ADDR 8'h04
`define MBH_OFF_WDATA 8'h08
`define MBH_OFF_CMD 8'h0C
`define MBH_OFF_STATUS 8'h10
`define MBH_OFF_RDATA 8'h14

// Control register fields
`define MBH_CTRL_MODE_LO 0
`define MBH_CTRL_MODE_HI 1
`define MBH_CTRL_ALE_POL 2
`define MBH_CTRL_RST 3'h0

// Mode encodings
`define MBH_MODE_MUX8 2'h0
`define MBH_MODE_MUX16 2'h1
`define MBH_MODE_NMX8 2'h2
`define MBH_MODE_NMX16 2'h3

// Command register fields
`define MBH_CMD_GO 0
`define MBH_CMD_READ 1
`define MBH_CMD_HIGH 2

// Status register fields
`define MBH_STAT_BUSY 0
`define MBH_STAT_DONE 1

// Timing
`define MBH_CLK_NS 25
`define MBH_T_ALE_NS 50
`define MBH_T_HOLD_NS 25
`define MBH_T_ACC_NS 100
`define MBH_T_REC_NS 25
`define MBH_CYC(t) (((t) + `MBH_CLK_NS - 1) / `MBH_CLK_NS)
`define MBH_ALE_CYC `MBH_CYC(`MBH_T_ALE_NS)
`define MBH_HOLD_CYC `MBH_CYC(`MBH_T_HOLD_NS)
`define MBH_ACC_CYC `MBH_CYC(`MBH_T_ACC_NS)
`define MBH_REC_CYC `MBH_CYC(`MBH_T_REC_NS)

`endif

// File: tb/mbh_ctrl_properties.sv
// Checker of host bus timing at the controller ports
`timescale 1ns/100ps
module mbh_ctrl_chk (
  // Clock and reset
  input wire core_clk_in,
  input wire sys_rst_in,
  // Strobes
  input wire address_latch_strobe_out,
  input wire rd_n_out,
  input wire wr_n_out,
  input wire byte_high_enable_n_out,
  // Pin enables and upper address
  input wire low_addr_data_pins_oe_n_out,
  input wire high_addr_data_pins_oe_n_out,
  input wire port_a_lines_oe_n_out,
  input wire port_b_lines_oe_n_out,
  input wire [2:0] port_c_lines_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Strobe pulse: active edge then trailing edge two cycles apart
  sequence s_pulse;
    $changed(address_latch_strobe_out) ##2
      $changed(address_latch_strobe_out);
  endsequence
  // Access strobes low for the whole access count, then high
  sequence s_rd_access;
    !rd_n_out [*4] ##1 rd_n_out;
  endsequence
  sequence s_wr_access;
    !wr_n_out [*4] ##1 wr_n_out;
  endsequence
  a_strobe_then_access: assert property (
    s_pulse |-> ##1 ($fell(rd_n_out) || $fell(wr_n_out)))
    else $error("no access after strobe");
  a_rw_exclusive: assert property (rd_n_out || wr_n_out)
    else $error("read and write both low");
  a_read_len: assert property ($fell(rd_n_out) |-> s_rd_access)
    else $error("read length");
  a_write_len: assert property ($fell(wr_n_out) |-> s_wr_access)
    else $error("write length");
  a_read_release: assert property (!rd_n_out |->
    port_a_lines_oe_n_out && port_b_lines_oe_n_out &&
    (low_addr_data_pins_oe_n_out || !high_addr_data_pins_oe_n_out))
    else $error("data lanes driven in read");
  a_write_drive: assert property (!wr_n_out |->
    !low_addr_data_pins_oe_n_out && !high_addr_data_pins_oe_n_out &&
    (port_b_lines_oe_n_out || !port_a_lines_oe_n_out))
    else $error("write lanes not driven");
  a_bhe_steady: assert property (
    (!rd_n_out || !wr_n_out) |-> $stable(byte_high_enable_n_out))
    else $error("byte high enable moved in access");
  a_bhe_end: assert property (
    $rose(byte_high_enable_n_out) |-> $past(rd_n_out) && $past(wr_n_out))
    else $error("byte high enable ended early");
  a_upper_steady: assert property (
    (!rd_n_out || !wr_n_out) |-> $stable(port_c_lines_out))
    else $error("upper address moved");
endmodule // mbh_ctrl_chk
bind mbh_ctrl mbh_ctrl_chk u_chk (.core_clk_in, .sys_rst_in,
  .address_latch_strobe_out, .rd_n_out, .wr_n_out, .byte_high_enable_n_out,
  .low_addr_data_pins_oe_n_out, .high_addr_data_pins_oe_n_out,
  .port_a_lines_oe_n_out, .port_b_lines_oe_n_out, .port_c_lines_out);

// File: tb/mbh_dev_model.sv
// Behavioural model of the peripheral's host bus
`timescale 1ns/100ps
module mbh_dev_model (
  // Configuration and strobes
  input wire [1:0] mode,
  input wire pol,
  input wire address_latch_strobe_out,
  input wire rd_n_out,
  input wire wr_n_out,
  // Host driven pins
  input wire [7:0] low_addr_data_pins_out,
  input wire [7:0] high_addr_data_pins_out,
  input wire [7:0] port_a_lines_out,
  input wire [7:0] port_b_lines_out,
  input wire [2:0] port_c_lines_out,
  // Device driven pins, latched address and decoder output
  output wire [7:0] low_addr_data_pins_in,
  output wire [7:0] high_addr_data_pins_in,
  output wire [7:0] port_a_lines_in,
  output wire [7:0] port_b_lines_in,
  output reg [18:0] adr,
  output wire pc_dec_n
);
  // Port C lines 0-1 are address inputs, line 2 a logic input
  localparam [2:0] PC_IS_ADDR = 3'b011;
  // Port B direction bits: line 7 input, the rest outputs
  localparam [7:0] PB_DIR = 8'h7F;
  wire [7:0] lo = low_addr_data_pins_out;
  wire [7:0] hi = high_addr_data_pins_out;
  wire [7:0] pa = port_a_lines_out;
  wire [7:0] pb = port_b_lines_out;
  // Mode decode
  wire mx = !mode[1];
  wire wd = mode[0];
  wire rd = !rd_n_out;
  wire ale_open = (address_latch_strobe_out == pol);
  reg [15:0] mem = 16'h0000;
  reg [7:0] cs_n;
  integer k;
  integer j;
  // Transparent latch, holds after trailing edge
  always @* begin
    if (ale_open)
      adr[15:0] = {hi, lo};
    for (k = 0; k < 3; k = k + 1)
      if (ale_open || !PC_IS_ADDR[k])
        adr[16 + k] = port_c_lines_out[k];
  end
  // Chip selects: lower lines use two of four terms, upper one of two
  always @* begin
    cs_n = 8'hFF;
    for (j = 0; j < 4; j = j + 1) begin
      if (adr[15:14] == j && (adr[13] || adr[12]))
        cs_n[j] = 1'b0;
      if (adr[11:10] == j && adr[9])
        cs_n[4 + j] = 1'b0;
    end
  end
  // Decoder output of a single product term
  assign pc_dec_n = !(adr[17] && adr[15]);
  // Write data taken from the mode's lanes
  always @(negedge wr_n_out) #5 mem = mx ? {wd ? hi : 8'h00, lo} :
    {wd ? pb : 8'h00, pa};
  // Read data only during reads, else the inverse of the host's drive
  assign low_addr_data_pins_in = rd && mx ? mem[7:0] : ~lo;
  assign high_addr_data_pins_in = rd && mx && wd ? mem[15:8] : ~hi;
  assign port_a_lines_in = rd && !mx ? mem[7:0] : ~pa;
  // Port B: 16-bit non-mux gives high data in reads, else inverse drive; other modes selects and pulled input
  assign port_b_lines_in = rd && !mx && wd ? mem[15:8] :
    !mx && wd ? ~pb : (cs_n & PB_DIR) | ~PB_DIR;
endmodule // mbh_dev_model

// File: tb/mbh_ctrl_tb_top.sv
// Self-checking bench for the microcontroller bus host
`timescale 1ns/100ps
`include "mbh_defines.vh"
module mbh_ctrl_tb_top;
  reg core_clk_in = 1'b0, sys_rst_in = 1'b1, pol = 1'b0, e;
  reg psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  reg [7:0] paddr_in = 8'h00;
  reg [31:0] pwdata_in = 32'h0, q;
  reg [1:0] mode = 2'h0;
  reg [19:0] a;
  reg [15:0] d;
  wire [31:0] prdata_out;
  wire pready_out, pslverr_out, address_latch_strobe_out, rd_n_out, wr_n_out;
  wire byte_high_enable_n_out, low_addr_data_pins_oe_n_out;
  wire high_addr_data_pins_oe_n_out, port_a_lines_oe_n_out;
  wire port_b_lines_oe_n_out, addr19_or_chip_select_in_out;
  wire [7:0] low_addr_data_pins_in, low_addr_data_pins_out;
  wire [7:0] high_addr_data_pins_in, high_addr_data_pins_out;
  wire [7:0] port_a_lines_in, port_a_lines_out;
  wire [7:0] port_b_lines_in, port_b_lines_out;
  wire [2:0] port_c_lines_out;
  wire [18:0] adr;
  wire pc_dec_n;
  integer n_fail = 0, n_compared = 0, cyc = 0, m;
  mbh_ctrl dut (.*);
  mbh_dev_model u_dev (.*);
  // Clock and timeout
  always #12.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      wrap_up;
    end
  end
  task wrap_up;
    begin
      $display("compared=%0d failed=%0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] x);
    begin
      n_compared = n_compared + 1;
      if (s !== x) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, x);
      end
    end
  endtask
  // One APB transfer, then one idle cycle
  task xfer(input w, input [7:0] ad, input [31:0] wd);
    begin
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= ad;
      pwdata_in <= wd;
      @(posedge core_clk_in) penable_in <= 1'b1;
      @(posedge core_clk_in);
      while (pready_out !== 1'b1)
        @(posedge core_clk_in);
      q = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      @(posedge core_clk_in);
    end
  endtask
  // Wait for done, then clear it
  task poll;
    begin
      q = 32'h0;
      while (q[1] !== 1'b1)
        xfer(1'b0, `MBH_OFF_STATUS, 32'h0);
      chk(q[1:0], 2'h2);
      xfer(1'b1, `MBH_OFF_STATUS, 32'h2);
    end
  endtask
  initial begin
    repeat (16) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    xfer(1'b0, `MBH_OFF_STATUS, 0);
    chk(q, 0);
    for (m = 0; m < 4; m = m + 1) begin
      mode <= m[1:0];
      pol <= (m == 1);
      a = 20'h9A5C3 ^ (m[19:0] * 20'h91111);
      d = 16'hC3A5 ^ (m[15:0] * 16'h1111);
      xfer(1'b1, `MBH_OFF_CTRL, {29'h0, m == 1, m[1:0]});
      xfer(1'b1, `MBH_OFF_ADDR, {12'h0, a});
      xfer(1'b1, `MBH_OFF_WDATA, {16'h0, d});
      xfer(1'b1, `MBH_OFF_CMD, {29'h0, m[0], 2'h1});
      poll;
      chk(adr, a[18:0]);
      chk(port_c_lines_out, a[18:16]);
      chk(addr19_or_chip_select_in_out, a[19]);
      chk(pc_dec_n, m < 2);
      if (m != 3) chk(port_b_lines_in, m == 2 ? 8'hDF : 8'hFB);
      xfer(1'b1, `MBH_OFF_CMD, {29'h0, m[0], 2'h3});
      poll;
      xfer(1'b0, `MBH_OFF_RDATA, 0);
      chk(q, m[0] ? d : d[7:0]);
    end
    xfer(1'b0, 8'h40, 0);
    chk(e, 1);
    chk(q, 0);
    wrap_up;
  end
endmodule // mbh_ctrl_tb_top
